// [design/host_port_pkg.sv]
// Shared types and constants for the asynchronous host port.
// Assumes one 100 MHz clock and a synchronous active-high reset.
package host_port_pkg;

   localparam int ADDR_W = 7;
   localparam int HDATA_W = 16;
   localparam int WORD_W = 32;
   localparam int REG_ADDR_W = 6;
   localparam int IRQ_SRC_W = 8;
   localparam int TX_BUF_DEPTH = 2;

   // Word addresses below this reach the data FIFO ports
   localparam logic [ADDR_W-1:0] FIFO_ADDR_TOP = 7'h10;
   // Word address bit that picks the half of a 32-bit word
   localparam int HALF_BIT = 0;
   localparam logic HALF_LO = 1'b0;
   localparam logic HALF_HI = 1'b1;
   localparam logic [HDATA_W-1:0] DOUT_RESET = 16'h0000;
   localparam logic [WORD_W-1:0] WORD_RESET = 32'h0000_0000;

   typedef struct packed {
      logic chip_select_n;
      logic read_strobe_n;
      logic write_strobe_n;
      logic fifo_sel;
      logic [ADDR_W-1:0] addr;
      logic [HDATA_W-1:0] data;
   } host_pins_t;

   localparam host_pins_t PINS_IDLE = '{1'b1, 1'b1, 1'b1, 1'b0, 7'h00,
                                        16'h0000};

   typedef struct packed {
      logic pol_high;
      logic open_drain;
      logic [IRQ_SRC_W-1:0] mask;
   } irq_cfg_t;

   typedef enum logic [1:0] {
      PH_IDLE = 2'b00,
      PH_REG_WAIT = 2'b01
   } rd_phase_t;

endpackage

// [design/word_buffer.sv]
// Two-entry word buffer with valid/ready on both sides.
// Assumes producer and consumer share the clock; head is a flop.
`timescale 1ns/100ps
module word_buffer #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 2
) (
   input wire logic i_clk,
   input wire logic i_srst,
   input wire logic i_in_valid,
   input wire logic [WIDTH-1:0] i_in_data,
   output logic o_in_ready,
   output logic o_out_valid,
   output logic [WIDTH-1:0] o_out_data,
   input wire logic i_out_ready
);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [DEPTH-1:0] vld;
   } buf_state_t;

   buf_state_t state;
   buf_state_t next_state;
   logic push;
   logic pop;
   logic placed;

   assign o_in_ready = !state.vld[DEPTH-1];
   assign o_out_valid = state.vld[0];
   assign o_out_data = state.mem[0];
   assign push = i_in_valid && o_in_ready;
   assign pop = state.vld[0] && i_out_ready;

   ////////////////////////////////////////////////////////////////////////
   // Shift on pop keeps the head in a fixed flop, no output mux
   always_comb begin
      next_state = state;
      placed = 1'b0;
      if (pop) begin
         for (int i = 0; i < DEPTH - 1; i++) begin
            next_state.mem[i] = state.mem[i+1];
            next_state.vld[i] = state.vld[i+1];
         end
         next_state.vld[DEPTH-1] = 1'b0;
      end
      for (int i = 0; i < DEPTH; i++) begin
         if (push && !placed && !next_state.vld[i]) begin
            next_state.mem[i] = i_in_data;
            next_state.vld[i] = 1'b1;
            placed = 1'b1;
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   chk_buf_no_gap: assert property (@(posedge i_clk) disable iff (i_srst)
      state.vld[DEPTH-1] |-> state.vld[0])
      else $error("buffer holds a gap");

endmodule

// [design/async_sram_host_port.sv]
// Asynchronous SRAM-style host port: strobes, address decode, FIFO ports.
// Assumes every host pin is asynchronous to i_clk and held for several
// clocks; the register file and FIFOs behind it share i_clk.
//
// Function
// - Seven-bit word address selects a register or a data FIFO port.
// - Read strobe low with chip select low requests read data.
// - Write strobe low with chip select low delivers bus data.
// - Strobes are ignored while chip select is high.
// - A write cycle during low power raises the wake request.
// - Interrupt output has programmable polarity, sources and drive style.
// - FIFO select high sends every access to the data FIFOs.
// - FIFO select high ignores the six upper address bits.
// - Sixteen-bit host transfers pair into 32-bit internal words.
`timescale 1ns/100ps
module async_sram_host_port (
   input wire logic i_clk,
   input wire logic i_srst,
   input wire host_port_pkg::host_pins_t i_host,
   output logic [host_port_pkg::HDATA_W-1:0] o_data,
   output logic o_data_oe,
   output logic o_reg_rd,
   output logic o_reg_wr,
   output logic [host_port_pkg::REG_ADDR_W-1:0] o_reg_addr,
   output logic [host_port_pkg::WORD_W-1:0] o_reg_wdata,
   input wire logic [host_port_pkg::WORD_W-1:0] i_reg_rdata,
   input wire logic i_rx_valid,
   input wire logic [host_port_pkg::WORD_W-1:0] i_rx_data,
   output logic o_rx_ready,
   output logic o_tx_valid,
   output logic [host_port_pkg::WORD_W-1:0] o_tx_data,
   input wire logic i_tx_ready,
   output logic o_tx_busy,
   output logic o_tx_overrun,
   input wire logic i_overrun_clr,
   input wire logic i_low_power,
   output logic o_wake,
   input wire logic [host_port_pkg::IRQ_SRC_W-1:0] i_irq_src,
   input wire host_port_pkg::irq_cfg_t i_irq_cfg,
   output logic o_irq,
   output logic o_irq_oe
);

   typedef struct packed {
      host_port_pkg::host_pins_t s1;
      host_port_pkg::host_pins_t s2;
      logic rd_prev;
      logic wr_prev;
      host_port_pkg::host_pins_t wlat;
      host_port_pkg::rd_phase_t phase;
      logic [host_port_pkg::HDATA_W-1:0] dout;
      logic doe;
      logic rx_ready;
      logic reg_rd;
      logic reg_wr;
      logic [host_port_pkg::REG_ADDR_W-1:0] reg_addr;
      logic [host_port_pkg::WORD_W-1:0] reg_wdata;
      logic [host_port_pkg::HDATA_W-1:0] reg_lo;
      logic [host_port_pkg::HDATA_W-1:0] reg_hi;
      logic [host_port_pkg::HDATA_W-1:0] tx_lo;
      logic pend;
      logic [host_port_pkg::WORD_W-1:0] tx_word;
      logic overrun;
      logic wake;
      logic irq;
      logic irq_oe;
   } port_state_t;

   port_state_t state;
   port_state_t next_state;
   logic rd_act;
   logic wr_act;
   logic rd_start;
   logic wr_start;
   logic wr_end;
   logic rd_fifo;
   logic wr_fifo;
   logic irq_active;
   logic buf_in_ready;
   logic tx_hi_commit;
   logic tx_drop;

   ////////////////////////////////////////////////////////////////////////
   // Strobe qualification on the synchronised pins
   assign rd_act = !state.s2.chip_select_n && !state.s2.read_strobe_n;
   assign wr_act = !state.s2.chip_select_n && !state.s2.write_strobe_n;
   assign rd_start = rd_act && !state.rd_prev;
   assign wr_start = wr_act && !state.wr_prev;
   assign wr_end = !wr_act && state.wr_prev;
   assign rd_fifo = state.s2.fifo_sel ||
                    (state.s2.addr < host_port_pkg::FIFO_ADDR_TOP);
   assign wr_fifo = state.wlat.fifo_sel ||
                    (state.wlat.addr < host_port_pkg::FIFO_ADDR_TOP);
   assign irq_active = |(i_irq_src & i_irq_cfg.mask);
   assign tx_hi_commit = wr_end && wr_fifo &&
                         state.wlat.addr[host_port_pkg::HALF_BIT] ==
                         host_port_pkg::HALF_HI;
   // Room frees this cycle if the buffer takes the pending word
   assign tx_drop = state.pend && !buf_in_ready;

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      next_state = state;
      // Two flops per pin; only s2 feeds logic
      next_state.s1 = i_host;
      next_state.s2 = state.s1;
      next_state.rd_prev = rd_act;
      next_state.wr_prev = wr_act;
      next_state.reg_rd = 1'b0;
      next_state.reg_wr = 1'b0;
      next_state.rx_ready = 1'b0;
      next_state.wake = i_low_power && wr_start;
      next_state.doe = rd_act;
      next_state.phase = host_port_pkg::PH_IDLE;

      // Data sampled each cycle of the write; committed at its end
      if (wr_act) begin
         next_state.wlat = state.s2;
      end

      // Read side
      if (rd_start) begin
         if (rd_fifo) begin
            // Only the half bit decides under FIFO select
            if (state.s2.addr[host_port_pkg::HALF_BIT] ==
                host_port_pkg::HALF_LO) begin
               next_state.dout = i_rx_data[host_port_pkg::HDATA_W-1:0];
            end else begin
               next_state.dout =
                  i_rx_data[host_port_pkg::WORD_W-1:host_port_pkg::HDATA_W];
               next_state.rx_ready = i_rx_valid;
            end
         end else if (state.s2.addr[host_port_pkg::HALF_BIT] ==
                      host_port_pkg::HALF_LO) begin
            next_state.reg_rd = 1'b1;
            next_state.reg_addr = state.s2.addr[host_port_pkg::ADDR_W-1:1];
            next_state.phase = host_port_pkg::PH_REG_WAIT;
         end else begin
            next_state.dout = state.reg_hi;
         end
      end

      case (state.phase)
         host_port_pkg::PH_IDLE: begin
         end
         host_port_pkg::PH_REG_WAIT: begin
            // Upper half kept so the pair reads one coherent word
            next_state.dout = i_reg_rdata[host_port_pkg::HDATA_W-1:0];
            next_state.reg_hi =
               i_reg_rdata[host_port_pkg::WORD_W-1:host_port_pkg::HDATA_W];
         end
         default: begin
            next_state.phase = host_port_pkg::PH_IDLE;
         end
      endcase

      // Pending word leaves first so a new one can take its place
      if (state.pend && buf_in_ready) begin
         next_state.pend = 1'b0;
      end

      // Write side
      if (wr_end) begin
         if (wr_fifo) begin
            if (state.wlat.addr[host_port_pkg::HALF_BIT] ==
                host_port_pkg::HALF_LO) begin
               next_state.tx_lo = state.wlat.data;
            end else if (tx_drop) begin
               // Host cannot be stalled; a word with no room is dropped
               next_state.overrun = 1'b1;
            end else begin
               next_state.pend = 1'b1;
               next_state.tx_word = {state.wlat.data, state.tx_lo};
            end
         end else if (state.wlat.addr[host_port_pkg::HALF_BIT] ==
                      host_port_pkg::HALF_LO) begin
            next_state.reg_lo = state.wlat.data;
         end else begin
            next_state.reg_wr = 1'b1;
            next_state.reg_addr = state.wlat.addr[host_port_pkg::ADDR_W-1:1];
            next_state.reg_wdata = {state.wlat.data, state.reg_lo};
         end
      end

      // Set wins over clear
      if (i_overrun_clr && !(tx_hi_commit && tx_drop)) begin
         next_state.overrun = 1'b0;
      end

      // Open drain drives only the active level
      next_state.irq = irq_active ? i_irq_cfg.pol_high
                                  : !i_irq_cfg.pol_high;
      next_state.irq_oe = i_irq_cfg.open_drain ? irq_active : 1'b1;
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         state <= '0;
         state.s1 <= host_port_pkg::PINS_IDLE;
         state.s2 <= host_port_pkg::PINS_IDLE;
         state.wlat <= host_port_pkg::PINS_IDLE;
         state.phase <= host_port_pkg::PH_IDLE;
      end else begin
         state <= next_state;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Transmit words wait here; a stalled consumer loses words once two are buffered and one is pending
   word_buffer #(
      .WIDTH(host_port_pkg::WORD_W),
      .DEPTH(host_port_pkg::TX_BUF_DEPTH)
   ) u_tx_buf (
      .i_clk(i_clk),
      .i_srst(i_srst),
      .i_in_valid(state.pend),
      .i_in_data(state.tx_word),
      .o_in_ready(buf_in_ready),
      .o_out_valid(o_tx_valid),
      .o_out_data(o_tx_data),
      .i_out_ready(i_tx_ready)
   );

   assign o_data = state.dout;
   assign o_data_oe = state.doe;
   assign o_reg_rd = state.reg_rd;
   assign o_reg_wr = state.reg_wr;
   assign o_reg_addr = state.reg_addr;
   assign o_reg_wdata = state.reg_wdata;
   assign o_rx_ready = state.rx_ready;
   assign o_tx_busy = state.pend;
   assign o_tx_overrun = state.overrun;
   assign o_wake = state.wake;
   assign o_irq = state.irq;
   assign o_irq_oe = state.irq_oe;

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_srst);

   chk_bus_drive_window: assert property (
      o_data_oe |-> !$past(state.s2.chip_select_n) &&
                    !$past(state.s2.read_strobe_n))
      else $error("data bus driven outside a read");

   chk_read_needs_select: assert property (
      $past(state.s2.chip_select_n) |-> !o_reg_rd)
      else $error("register read without chip select");

   chk_read_request: assert property (
      (rd_start && !rd_fifo && !state.s2.addr[0]) |=>
         o_reg_rd ##1 !o_reg_rd)
      else $error("register read pulse wrong");

   chk_write_commit: assert property (
      (wr_end && !wr_fifo && state.wlat.addr[0]) |=>
         o_reg_wr && o_reg_wdata[15:0] == $past(state.reg_lo))
      else $error("register write not committed");

   chk_wake_on_write: assert property (
      (i_low_power && wr_start) |=> o_wake)
      else $error("write in low power did not wake");

   chk_irq_drive_style: assert property (
      ($past(i_irq_cfg.open_drain) && !$past(irq_active)) |-> !o_irq_oe)
      else $error("open-drain interrupt driven while idle");

   chk_fifo_override: assert property (
      (rd_start && state.s2.fifo_sel) |=> !o_reg_rd)
      else $error("FIFO select access reached registers");

   chk_upper_ignored: assert property (
      (rd_start && state.s2.fifo_sel && state.s2.addr[0] && i_rx_valid)
         |=> o_rx_ready)
      else $error("FIFO high half read did not pop");

   chk_reg_decode: assert property (
      o_reg_rd |-> o_reg_addr == $past(state.s2.addr[6:1]))
      else $error("register address decode wrong");

   chk_tx_push: assert property (
      (tx_hi_commit && !tx_drop) |=> o_tx_busy)
      else $error("assembled transmit word not queued");

   chk_overrun_set_wins: assert property (
      (tx_hi_commit && tx_drop) |=> o_tx_overrun)
      else $error("dropped transmit word not flagged");

   chk_wake_quiet: assert property (
      !(i_low_power && wr_start) |=> !o_wake)
      else $error("wake pulse without a write");

   chk_rx_pop_high: assert property (
      o_rx_ready |-> $past(rd_start && rd_fifo && state.s2.addr[0]))
      else $error("receive pop outside a high half read");

   cov_reg_read: cover property (o_reg_rd ##[1:20] o_data_oe);
   cov_tx_word: cover property (state.pend ##1 o_tx_valid);
   cov_wake: cover property (o_wake);
   cov_overrun: cover property ($rose(o_tx_overrun));
   cov_rx_pop: cover property (o_rx_ready);

endmodule

// [tb/host_model.sv]
// Host processor model: drives strobes, address and its half of the bus.
// Assumes the device data output and enable are fed back to it.
`timescale 1ns/100ps
module host_model (
   input wire logic i_clk,
   input wire logic [host_port_pkg::HDATA_W-1:0] i_dev_data,
   input wire logic i_dev_oe,
   output host_port_pkg::host_pins_t o_pins
);
   host_port_pkg::host_pins_t pins = host_port_pkg::PINS_IDLE;
   logic drv = 1'b0;
   logic [15:0] pat = 16'h5A5A;
   ////////////////////////////////////////////////////////////////////////
   always @(posedge i_clk) begin
      pat <= ~pat;
   end
   // Undriven bus shows a toggling pattern, never the last value
   always_comb begin
      o_pins = pins;
      if (!drv) begin
         o_pins.data = i_dev_oe ? i_dev_data : pat;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // Strobe low 6 clocks, high 8 clocks: above the 4-clock minimum
   task automatic access(input logic wr, input logic fsel, input logic csn,
      input logic [6:0] a, input logic [15:0] wd, output logic [15:0] rd,
      output logic oe);
      @(posedge i_clk);
      pins.fifo_sel <= fsel;
      pins.addr <= a;
      pins.data <= wd;
      drv <= wr;
      @(posedge i_clk);
      pins.chip_select_n <= csn;
      pins.read_strobe_n <= wr;
      pins.write_strobe_n <= !wr;
      repeat (6) @(posedge i_clk);
      rd = o_pins.data;
      oe = i_dev_oe;
      pins.chip_select_n <= 1'b1;
      pins.read_strobe_n <= 1'b1;
      pins.write_strobe_n <= 1'b1;
      @(posedge i_clk);
      drv <= 1'b0;
      repeat (5) @(posedge i_clk);
   endtask
endmodule

// [tb/tb.sv]
// Self-checking bench: registers, data FIFOs, wake and interrupt pin.
// Assumes host_model drives the pins; register file is modelled here.
`timescale 1ns/100ps
module tb;
   localparam logic [6:0] WAKE_ADDR = 7'h32; // Stand-in wake register
   logic i_clk = 1'b0;
   logic i_srst = 1'b1;
   host_port_pkg::host_pins_t pins;
   logic [15:0] o_data;
   logic o_data_oe, o_reg_rd, o_reg_wr, o_rx_ready, o_tx_valid, o_tx_busy;
   logic o_tx_overrun, o_wake, o_irq, o_irq_oe;
   logic [5:0] o_reg_addr;
   logic [31:0] o_reg_wdata, o_tx_data, i_reg_rdata, i_rx_data = '0;
   logic i_rx_valid = 1'b1, i_tx_ready = 1'b0, i_overrun_clr = 1'b0;
   logic i_low_power = 1'b0, rand_ready = 1'b0;
   logic [7:0] i_irq_src = '0;
   host_port_pkg::irq_cfg_t i_irq_cfg = '0;
   logic [31:0] regmem [64];
   logic [31:0] exp_reg [int];
   logic [31:0] tx_q [$];
   int n_errors = 0, checked = 0, cycles = 0, wakes = 0;
   always #5 i_clk = ~i_clk;
   async_sram_host_port async_sram_host_port_i (.i_clk(i_clk),
      .i_srst(i_srst), .i_host(pins), .o_data(o_data),
      .o_data_oe(o_data_oe), .o_reg_rd(o_reg_rd), .o_reg_wr(o_reg_wr),
      .o_reg_addr(o_reg_addr), .o_reg_wdata(o_reg_wdata),
      .i_reg_rdata(i_reg_rdata), .i_rx_valid(i_rx_valid),
      .i_rx_data(i_rx_data), .o_rx_ready(o_rx_ready),
      .o_tx_valid(o_tx_valid), .o_tx_data(o_tx_data),
      .i_tx_ready(i_tx_ready), .o_tx_busy(o_tx_busy),
      .o_tx_overrun(o_tx_overrun), .i_overrun_clr(i_overrun_clr),
      .i_low_power(i_low_power), .o_wake(o_wake), .i_irq_src(i_irq_src),
      .i_irq_cfg(i_irq_cfg), .o_irq(o_irq), .o_irq_oe(o_irq_oe));
   host_model host_model_i (.i_clk(i_clk), .i_dev_data(o_data),
      .i_dev_oe(o_data_oe), .o_pins(pins));
   ////////////////////////////////////////////////////////////////////////
   task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: word %h want %h", $time, got, exp);
      end
   endtask
   task automatic cmp1(input logic got, input logic exp);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: flag %b want %b", $time, got, exp);
      end
   endtask
   task automatic end_of_test();
      if (n_errors == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic xfer32(input logic wr, input logic fsel, input logic csn,
      input logic [6:0] a, input logic [31:0] wd, output logic [31:0] rd,
      output logic oe);
      logic o0;
      host_model_i.access(wr, fsel, csn, {a[6:1], 1'b0}, wd[15:0],
         rd[15:0], o0);
      host_model_i.access(wr, fsel, csn, {a[6:1], 1'b1}, wd[31:16],
         rd[31:16], oe);
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Register file answers while o_reg_rd stands; the port captures then
   assign i_reg_rdata = regmem[o_reg_addr];
   // Register file, RX head, TX consumer and the run limit
   always @(posedge i_clk) begin
      cycles <= cycles + 1;
      if (o_reg_wr) regmem[o_reg_addr] <= o_reg_wdata;
      if (o_rx_ready) i_rx_data <= $urandom;
      if (o_wake) wakes <= wakes + 1;
      if (rand_ready) i_tx_ready <= 1'($urandom);
      if (o_tx_valid && i_tx_ready) cmp32(o_tx_data, tx_q.pop_front());
      if (cycles == 20000) begin
         n_errors = n_errors + 1;
         end_of_test();
      end
   end
   ////////////////////////////////////////////////////////////////////////
   initial begin
      logic [31:0] d, r, x;
      logic [6:0] a;
      logic oe, act;
      void'($urandom(60137));
      repeat (5) @(posedge i_clk);
      i_srst <= 1'b0;
      i_rx_data <= $urandom;
      cmp1(o_data_oe, 1'b0);
      for (int i = 0; i < 4; i++) begin
         a = 7'(($urandom % 56 + 8) * 2);
         d = $urandom;
         xfer32(1'b1, 1'b0, 1'b0, a, d, x, oe);
         xfer32(1'b1, 1'b0, 1'b1, a, ~d, x, oe);
         exp_reg[a[6:1]] = d;
         xfer32(1'b0, 1'b0, 1'b0, a, '0, r, oe);
         cmp32(r, exp_reg[a[6:1]]);
         cmp1(oe, 1'b1);
         xfer32(1'b0, 1'b0, 1'b1, a, '0, r, oe);
         cmp1(oe, 1'b0);
         cmp1(o_data_oe, 1'b0);
      end
      // Lone half to the wake register: wakes without a register write
      i_low_power <= 1'b1;
      host_model_i.access(1'b1, 1'b0, 1'b0, WAKE_ADDR, 16'h0001, x[15:0],
         oe);
      host_model_i.access(1'b0, 1'b0, 1'b0, WAKE_ADDR, '0, x[15:0], oe);
      host_model_i.access(1'b1, 1'b0, 1'b1, WAKE_ADDR, 16'h0002, x[15:0], oe);
      cmp32(32'(wakes), 32'h1);
      i_low_power <= 1'b0;
      for (int i = 0; i < 8; i++) begin
         i_irq_src <= 8'($urandom);
         i_irq_cfg <= 10'($urandom);
         repeat (3) @(posedge i_clk);
         act = |(i_irq_src & i_irq_cfg.mask);
         cmp1(o_irq, act ? i_irq_cfg.pol_high : !i_irq_cfg.pol_high);
         cmp1(o_irq_oe, i_irq_cfg.open_drain ? act : 1'b1);
      end
      // Consumer stalled: two buffered, one waiting, fourth dropped
      for (int i = 0; i < 4; i++) begin
         d = $urandom;
         if (i < 3) tx_q.push_back(d);
         a = 7'($urandom);
         xfer32(1'b1, i[0], 1'b0, i[0] ? a : {3'h0, a[3:0]}, d, x, oe);
      end
      cmp1(o_tx_busy, 1'b1);
      cmp1(o_tx_overrun, 1'b1);
      rand_ready <= 1'b1;
      repeat (60) @(posedge i_clk);
      cmp32(32'(tx_q.size()), 32'h0);
      i_overrun_clr <= 1'b1;
      @(posedge i_clk);
      i_overrun_clr <= 1'b0;
      repeat (2) @(posedge i_clk);
      cmp1(o_tx_overrun, 1'b0);
      for (int i = 0; i < 3; i++) begin
         d = i_rx_data;
         a = 7'($urandom);
         i_rx_valid <= 1'(i != 1);
         xfer32(1'b0, i[0], 1'b0, i[0] ? a : {3'h0, a[3:0]}, '0, r, oe);
         cmp32(r, d);
         cmp1(i_rx_data != d, i_rx_valid);
      end
      end_of_test();
   end
endmodule
